// ### mam_addr_meas.sv
// serial address selection, calibration mode and measurement result formatting
//
// Overview of operation
// - multipart mode takes address bits from straps
// - factory address A0, multipart enable cleared
// - single-mode address field in config two
// - calibration select defaults external, one internal
// - temperature stored as received, voltage too in external mode
// - bias low byte zero in external mode, high byte stored as received
// - transmit power low byte zero in external mode, high stored as received
// - monitor reference chosen by config one bit
// - receive power spans two bytes, sixteenths in external mode
// - calibration constants stored and readable back
// - internal mode corrects all results but temperature before storing
//
// Chosen here: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none

module mam_addr_meas #(
    parameter int DATA_W = 16
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [mam_pkg::BUS_ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [mam_pkg::BUS_DATA_W-1:0] writedata,
    input wire logic [mam_pkg::BUS_BE_W-1:0] byteenable,
    output logic [mam_pkg::BUS_DATA_W-1:0] readdata,
    output logic waitrequest,
    input wire logic strap_addr_lo,
    input wire logic strap_addr_hi,
    input wire mam_pkg::mam_conv_t conv,
    input wire mam_pkg::mam_ser_req_t ser_req,
    output logic ser_resp_valid,
    output logic ser_ack,
    output logic monitor_ref_select,
    output logic internal_cal_select
);

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    // the result formats assume a sixteen-bit left-aligned word
    if (DATA_W != 16) begin : g_bad_width
        $error("mam_addr_meas: DATA_W must be 16");
    end

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    // merge byte lanes 0 and 1 of a write into a 16-bit field
    function automatic logic [15:0] merge16(input logic [15:0] old_val,
                                            input logic [31:0] wdata,
                                            input logic [3:0] be);
        logic [15:0] res;
        res = old_val;
        if (be[0]) begin
            res[7:0] = wdata[7:0];
        end
        if (be[1]) begin
            res[15:8] = wdata[15:8];
        end
        return res;
    endfunction

    // slope (8.8 unsigned) times sample, rounded, plus signed offset, clamped
    function automatic logic [15:0] cal_apply(input logic [15:0] sample,
                                              input logic [15:0] slope,
                                              input logic [15:0] offset);
        logic [31:0] prod;
        logic [17:0] sum;
        logic [15:0] res;
        prod = sample * slope;
        sum = {2'b00, prod[23:8]} + {17'h00000, prod[7]} + {{2{offset[15]}}, offset};
        if (sum[17]) begin
            // negative result clamps to zero
            res = 16'h0000;
        end else if (sum[16] || (prod[31:24] != 8'h00)) begin
            // overflow clamps to full scale
            res = 16'hFFFF;
        end else begin
            res = sum[15:0];
        end
        return res;
    endfunction

    // ----------------------------------------------------------------
    // state declarations
    // ----------------------------------------------------------------
    logic [7:0] cfg_one_ff, nxt_cfg_one;        // holds monitor reference bit
    logic [7:0] cfg_two_ff, nxt_cfg_two;        // holds single-mode address
    logic [7:0] cfg_three_ff, nxt_cfg_three;    // holds calibration select
    logic [7:0] cfg_five_ff, nxt_cfg_five;      // holds multipart enable
    logic [15:0] cal_ff [mam_pkg::CAL_WORDS];   // calibration constants
    logic [15:0] nxt_cal [mam_pkg::CAL_WORDS];
    logic wait_ff, nxt_wait;                    // waitrequest register
    logic [31:0] rdata_ff, nxt_rdata;           // read data register
    logic [15:0] temp_ff, nxt_temp;             // temperature_result
    logic [15:0] volt_ff, nxt_volt;             // supply_voltage_result
    logic [15:0] bias_ff, nxt_bias;             // bias_result_high:low
    logic [15:0] txp_ff, nxt_txp;               // tx_power_result_high:low
    logic [15:0] rxp_ff, nxt_rxp;               // rx_power_result_high:low
    logic [1:0] strap_ff, nxt_strap;            // sampled strap levels
    logic ack_ff, nxt_ack;                      // serial acknowledge
    logic resp_ff, nxt_resp;                    // serial answer strobe

    // ----------------------------------------------------------------
    // combinational helpers
    // ----------------------------------------------------------------
    logic req;                                  // a bus request is present
    logic wr_take;                              // write completes this edge
    logic in_cal;                               // address falls on constants
    logic [7:0] cal_rel;                        // byte offset into constants
    logic [2:0] cal_idx;                        // constant word index
    logic [7:0] eff_addr;                       // address answered on the bus
    logic multi_on;                             // multipart mode active
    logic internal_cal_select_on;                            // internal calibration active

    assign req = read | write;
    assign wr_take = write & ~wait_ff;
    assign cal_rel = address - mam_pkg::REG_CAL_BASE;
    assign in_cal = (address >= mam_pkg::REG_CAL_BASE) && (cal_rel < mam_pkg::REG_CAL_SPAN);
    assign cal_idx = cal_rel[4:2];
    assign multi_on = cfg_five_ff[mam_pkg::CFG5_MULTI_BIT];
    assign internal_cal_select_on = cfg_three_ff[mam_pkg::CFG3_INTERNAL_CAL_SELECT_BIT];

    // effective address: single-mode field, straps override two bits in multipart mode
    always_comb begin
        eff_addr = {cfg_two_ff[7:mam_pkg::CFG2_ADDR_LSB], 4'h0};
        if (multi_on) begin
            eff_addr[mam_pkg::SER_STRAP_LO_BIT] = strap_ff[0];
            eff_addr[mam_pkg::SER_STRAP_HI_BIT] = strap_ff[1];
        end
    end

    // ----------------------------------------------------------------
    // register bus and configuration: next values
    // ----------------------------------------------------------------
    // one wait cycle per access; writes land when waitrequest is low
    always_comb begin
        nxt_wait = ~(req & wait_ff);
        nxt_rdata = rdata_ff;
        nxt_cfg_one = cfg_one_ff;
        nxt_cfg_two = cfg_two_ff;
        nxt_cfg_three = cfg_three_ff;
        nxt_cfg_five = cfg_five_ff;
        for (int i = 0; i < mam_pkg::CAL_WORDS; i++) begin
            nxt_cal[i] = cal_ff[i];
        end
        // read data is captured in the wait cycle, shown in the answer cycle
        if (read && wait_ff) begin
            nxt_rdata = 32'h0000_0000;
            if (in_cal) begin
                nxt_rdata[15:0] = cal_ff[cal_idx];
            end else begin
                case (address)
                    mam_pkg::REG_CFG_ONE: begin
                        nxt_rdata[7:0] = cfg_one_ff;
                    end
                    mam_pkg::REG_CFG_TWO: begin
                        nxt_rdata[7:0] = cfg_two_ff;
                    end
                    mam_pkg::REG_CFG_THREE: begin
                        nxt_rdata[7:0] = cfg_three_ff;
                    end
                    mam_pkg::REG_CFG_FIVE: begin
                        nxt_rdata[7:0] = cfg_five_ff;
                    end
                    mam_pkg::REG_STATUS: begin
                        nxt_rdata[9:0] = {strap_ff, eff_addr};
                    end
                    mam_pkg::REG_TEMP: begin
                        nxt_rdata[15:0] = temp_ff;
                    end
                    mam_pkg::REG_VOLT: begin
                        nxt_rdata[15:0] = volt_ff;
                    end
                    mam_pkg::REG_BIAS: begin
                        nxt_rdata[15:0] = bias_ff;
                    end
                    mam_pkg::REG_TXP: begin
                        nxt_rdata[15:0] = txp_ff;
                    end
                    mam_pkg::REG_RXP: begin
                        nxt_rdata[15:0] = rxp_ff;
                    end
                    default: begin
                        nxt_rdata = 32'h0000_0000; // unmapped reads return zero
                    end
                endcase
            end
        end
        // writes take effect only on the edge that completes the access
        if (wr_take && in_cal) begin
            // constants stored, each byte lane on its own
            nxt_cal[cal_idx] = merge16(cal_ff[cal_idx], writedata, byteenable);
        end else if (wr_take && byteenable[0]) begin
            case (address)
                mam_pkg::REG_CFG_ONE: begin
                    nxt_cfg_one = writedata[7:0];
                end
                mam_pkg::REG_CFG_TWO: begin
                    nxt_cfg_two = writedata[7:0];
                end
                mam_pkg::REG_CFG_THREE: begin
                    nxt_cfg_three = writedata[7:0];
                end
                mam_pkg::REG_CFG_FIVE: begin
                    nxt_cfg_five = writedata[7:0];
                end
                default: begin
                    nxt_cfg_one = cfg_one_ff; // read-only and unmapped writes are dropped
                end
            endcase
        end
    end

    // register bus and configuration: registers
    always_ff @(posedge clk) begin
        if (srst) begin
            wait_ff <= 1'b1;
            rdata_ff <= 32'h0000_0000;
            cfg_one_ff <= mam_pkg::CFG1_RST;
            cfg_two_ff <= mam_pkg::CFG2_RST;
            cfg_three_ff <= mam_pkg::CFG3_RST;
            cfg_five_ff <= mam_pkg::CFG5_RST;
            for (int i = 0; i < mam_pkg::CAL_WORDS; i++) begin
                cal_ff[i] <= (i % 2 == 0) ? mam_pkg::CAL_SLOPE_RST : mam_pkg::CAL_OFFSET_RST;
            end
        end else begin
            wait_ff <= nxt_wait;
            rdata_ff <= nxt_rdata;
            cfg_one_ff <= nxt_cfg_one;
            cfg_two_ff <= nxt_cfg_two;
            cfg_three_ff <= nxt_cfg_three;
            cfg_five_ff <= nxt_cfg_five;
            for (int i = 0; i < mam_pkg::CAL_WORDS; i++) begin
                cal_ff[i] <= nxt_cal[i];
            end
        end
    end

    // ----------------------------------------------------------------
    // measurement results: next values
    // ----------------------------------------------------------------
    // each converter strobe updates the matching result word
    always_comb begin
        nxt_temp = temp_ff;
        nxt_volt = volt_ff;
        nxt_bias = bias_ff;
        nxt_txp = txp_ff;
        nxt_rxp = rxp_ff;
        if (conv.valid) begin
            case (conv.channel)
                mam_pkg::CH_TEMP: begin
                    nxt_temp = conv.data;
                end
                mam_pkg::CH_VOLT: begin
                    if (internal_cal_select_on) begin
                        nxt_volt = cal_apply(conv.data, cal_ff[2 * mam_pkg::SET_VOLT],
                                             cal_ff[2 * mam_pkg::SET_VOLT + 1]);
                    end else begin
                        nxt_volt = conv.data;
                    end
                end
                mam_pkg::CH_BIAS: begin
                    if (internal_cal_select_on) begin
                        nxt_bias = cal_apply(conv.data, cal_ff[2 * mam_pkg::SET_BIAS],
                                             cal_ff[2 * mam_pkg::SET_BIAS + 1]);
                    end else begin
                        nxt_bias = conv.data & mam_pkg::MASK_HIGH_BYTE;
                    end
                end
                mam_pkg::CH_TXP: begin
                    if (internal_cal_select_on) begin
                        nxt_txp = cal_apply(conv.data, cal_ff[2 * mam_pkg::SET_TXP],
                                            cal_ff[2 * mam_pkg::SET_TXP + 1]);
                    end else begin
                        nxt_txp = conv.data & mam_pkg::MASK_HIGH_BYTE;
                    end
                end
                mam_pkg::CH_RXP: begin
                    if (internal_cal_select_on) begin
                        nxt_rxp = cal_apply(conv.data, cal_ff[2 * mam_pkg::SET_RXP],
                                            cal_ff[2 * mam_pkg::SET_RXP + 1]);
                    end else begin
                        nxt_rxp = conv.data & mam_pkg::MASK_RX;
                    end
                end
                default: begin
                    nxt_temp = temp_ff; // unknown channel codes leave results alone
                end
            endcase
        end
    end

    // measurement results: registers
    always_ff @(posedge clk) begin
        if (srst) begin
            temp_ff <= 16'h0000;
            volt_ff <= 16'h0000;
            bias_ff <= 16'h0000;
            txp_ff <= 16'h0000;
            rxp_ff <= 16'h0000;
        end else begin
            temp_ff <= nxt_temp;
            volt_ff <= nxt_volt;
            bias_ff <= nxt_bias;
            txp_ff <= nxt_txp;
            rxp_ff <= nxt_rxp;
        end
    end

    // ----------------------------------------------------------------
    // serial address match: next values
    // ----------------------------------------------------------------
    // straps sampled every cycle; address compared without the r/w bit
    always_comb begin
        nxt_strap = {strap_addr_hi, strap_addr_lo};
        nxt_resp = ser_req.valid;
        nxt_ack = ser_req.valid && (ser_req.addr[7:1] == eff_addr[7:1]);
    end

    // serial address match: registers
    always_ff @(posedge clk) begin
        if (srst) begin
            strap_ff <= 2'h0;
            resp_ff <= 1'b0;
            ack_ff <= 1'b0;
        end else begin
            strap_ff <= nxt_strap;
            resp_ff <= nxt_resp;
            ack_ff <= nxt_ack;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign readdata = rdata_ff;
    assign waitrequest = wait_ff;
    assign ser_resp_valid = resp_ff;
    assign ser_ack = ack_ff;
    assign monitor_ref_select = cfg_one_ff[mam_pkg::CFG1_REF_BIT];
    assign internal_cal_select = internal_cal_select_on;

endmodule
`default_nettype wire

// ### mam_addr_meas_sva.sv
// checker for bus timing, serial answers and result formats
`timescale 1ns/1ps
`default_nettype none
module mam_addr_meas_chk (
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic strap_addr_lo,
    input wire logic strap_addr_hi,
    input wire mam_pkg::mam_conv_t conv,
    input wire mam_pkg::mam_ser_req_t ser_req,
    input wire logic ser_resp_valid,
    input wire logic ser_ack,
    input wire logic monitor_ref_select,
    input wire logic internal_cal_select
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // ------------------------------------------------------------
    // bus handshake and serial answer timing
    // ------------------------------------------------------------
    a_wait_single: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("access not answered after one wait cycle");
    a_wait_pulse: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low longer than one cycle");
    a_resp_follows: assert property (ser_req.valid |=> ser_resp_valid)
        else $error("serial request without answer");
    a_resp_alone: assert property (!ser_req.valid |=> !ser_resp_valid)
        else $error("serial answer without request");
    a_ack_in_resp: assert property (ser_ack |-> ser_resp_valid)
        else $error("acknowledge outside answer cycle");
    // ------------------------------------------------------------
    // mode selects and result formats
    // ------------------------------------------------------------
    a_cal_write: assert property (write && !waitrequest && address == mam_pkg::REG_CFG_THREE && byteenable[0]
        |=> internal_cal_select == $past(writedata[0])) else $error("calibration select not written");
    a_cal_steady: assert property ($changed(internal_cal_select)
        |-> $past(write && !waitrequest && address == mam_pkg::REG_CFG_THREE)) else $error("calibration select moved");
    a_ref_write: assert property (write && !waitrequest && address == mam_pkg::REG_CFG_ONE && byteenable[0]
        |=> monitor_ref_select == $past(writedata[0])) else $error("monitor reference not written");
    a_bias_low: assert property (read && !waitrequest && address == mam_pkg::REG_BIAS && !internal_cal_select
        |-> readdata[7:0] == 8'h00) else $error("bias low byte not zero");
    a_tx_low: assert property (read && !waitrequest && address == mam_pkg::REG_TXP && !internal_cal_select
        |-> readdata[7:0] == 8'h00) else $error("tx power low byte not zero");
endmodule
bind mam_addr_meas mam_addr_meas_chk mam_addr_meas_chk_inst (.clk(clk), .srst(srst), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .strap_addr_lo(strap_addr_lo), .strap_addr_hi(strap_addr_hi), .conv(conv),
    .ser_req(ser_req), .ser_resp_valid(ser_resp_valid), .ser_ack(ser_ack),
    .monitor_ref_select(monitor_ref_select), .internal_cal_select(internal_cal_select));
`default_nettype wire

// ### mam_host_model.sv
// serial host that sends address bytes and collects acknowledges
`timescale 1ns/1ps
`default_nettype none
module mam_host_model (
    input wire logic clk,
    input wire logic ser_resp_valid,
    input wire logic ser_ack,
    output var mam_pkg::mam_ser_req_t ser_req
);
    initial ser_req = '0;
    // one address byte, answer taken one cycle after it is seen
    task automatic probe(input logic [7:0] a, output logic ack);
        @(posedge clk);
        ser_req <= {1'b1, a};
        @(posedge clk);
        // released lines must not keep the last byte
        ser_req <= {1'b0, ~a};
        @(posedge clk);
        // answer only counts in its own cycle
        ack = (ser_resp_valid === 1'b1) ? ser_ack : 1'bx;
    endtask
endmodule
`default_nettype wire

// ### mam_pkg.sv
// shared constants and carrier types for the serial address and measurement block
`default_nettype none

package mam_pkg;

    // ----------------------------------------------------------------
    // register bus geometry
    // ----------------------------------------------------------------
    localparam int BUS_ADDR_W = 8;                 // byte address width
    localparam int BUS_DATA_W = 32;                // data width
    localparam int BUS_BE_W = 4;                   // byte enable width

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_CFG_ONE = 8'h00;    // oem_config_one
    localparam logic [7:0] REG_CFG_TWO = 8'h04;    // oem_config_two
    localparam logic [7:0] REG_CFG_THREE = 8'h08;  // oem_config_three
    localparam logic [7:0] REG_CFG_FIVE = 8'h0C;   // oem_config_five
    localparam logic [7:0] REG_STATUS = 8'h10;     // effective address and straps
    localparam logic [7:0] REG_TEMP = 8'h20;       // temperature_result
    localparam logic [7:0] REG_VOLT = 8'h24;       // supply_voltage_result
    localparam logic [7:0] REG_BIAS = 8'h28;       // bias_result_high:bias_result_low
    localparam logic [7:0] REG_TXP = 8'h2C;        // tx_power_result_high:low
    localparam logic [7:0] REG_RXP = 8'h30;        // rx_power_result_high:low
    localparam logic [7:0] REG_CAL_BASE = 8'h40;   // first calibration constant word
    localparam logic [7:0] REG_CAL_SPAN = 8'h20;   // bytes covered by the constants

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int CFG1_REF_BIT = 0;               // monitor_ref_select
    localparam int CFG2_ADDR_LSB = 4;              // single-mode address field [7:4]
    localparam int CFG3_INTERNAL_CAL_SELECT_BIT = 0;            // internal_cal_select
    localparam int CFG5_MULTI_BIT = 3;             // multipart enable
    localparam int SER_STRAP_LO_BIT = 3;           // address bit fed by first strap
    localparam int SER_STRAP_HI_BIT = 4;           // address bit fed by second strap
    localparam logic [7:0] CFG1_RST = 8'h00;
    localparam logic [7:0] CFG2_RST = 8'hA0;       // factory address A0
    localparam logic [7:0] CFG3_RST = 8'h00;       // external calibration
    localparam logic [7:0] CFG5_RST = 8'h00;       // multipart off
    localparam logic [15:0] CAL_SLOPE_RST = 16'h0100;  // slope of one, 8.8 format
    localparam logic [15:0] CAL_OFFSET_RST = 16'h0000; // offset of zero

    // ----------------------------------------------------------------
    // converter channels, calibration sets and result masks
    // ----------------------------------------------------------------
    localparam logic [2:0] CH_TEMP = 3'h0;
    localparam logic [2:0] CH_VOLT = 3'h1;
    localparam logic [2:0] CH_BIAS = 3'h2;
    localparam logic [2:0] CH_TXP = 3'h3;
    localparam logic [2:0] CH_RXP = 3'h4;
    localparam int CAL_WORDS = 8;                  // slope,offset for four channels
    localparam logic [1:0] SET_VOLT = 2'h0;
    localparam logic [1:0] SET_BIAS = 2'h1;
    localparam logic [1:0] SET_TXP = 2'h2;
    localparam logic [1:0] SET_RXP = 2'h3;
    localparam logic [15:0] MASK_HIGH_BYTE = 16'hFF00; // low byte reads zero
    localparam logic [15:0] MASK_RX = 16'hFFF0;        // low byte counts in sixteenths

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic valid;          // one-cycle conversion strobe
        logic [2:0] channel;  // which measurement
        logic [15:0] data;    // raw converter word, left aligned
    } mam_conv_t;

    typedef struct packed {
        logic valid;          // one-cycle address strobe
        logic [7:0] addr;     // received address byte, bit 0 is read/write
    } mam_ser_req_t;

endpackage

`default_nettype wire

// ### tb_mam_addr_meas.sv
// self-checking bench for the address and measurement block
`timescale 1ns/1ps
`default_nettype none
module tb_mam_addr_meas;
    logic clk = 1'b0, srst = 1'b1, read, write, strap_lo, strap_hi, ack, mref, ical, rv, sa;
    logic [7:0] address;
    logic [31:0] writedata, readdata, q;
    logic [3:0] byteenable;
    logic waitrequest;
    logic [1:0] sv;
    mam_pkg::mam_conv_t conv;
    mam_pkg::mam_ser_req_t ser_req;
    int error_cnt = 0, n_checks = 0;
    logic [15:0] din [5] = '{16'h8765, 16'h4321, 16'h1234, 16'hABCD, 16'h5678};
    logic [15:0] dex [5] = '{16'h8765, 16'h4321, 16'h1200, 16'hAB00, 16'h5670};
    always #2.5 clk = ~clk;
    mam_addr_meas mam_addr_meas_inst (.clk(clk), .srst(srst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .strap_addr_lo(strap_lo), .strap_addr_hi(strap_hi), .conv(conv), .ser_req(ser_req),
        .ser_resp_valid(rv), .ser_ack(sa), .monitor_ref_select(mref), .internal_cal_select(ical));
    mam_host_model mam_host_model_inst (.clk(clk), .ser_resp_valid(rv), .ser_ack(sa), .ser_req(ser_req));
    // ------------------------------------------------------------
    // compare, bus and stimulus tasks
    // ------------------------------------------------------------
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %0t word %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk_bit(input logic g, input logic e);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %0t bit %b expected %b", $time, g, e);
        end
    endtask
    // one access held until waitrequest is seen low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        address <= a;
        writedata <= d;
        byteenable <= 4'hF;
        read <= !w;
        write <= w;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (waitrequest !== 1'b0 && i < 20);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (i >= 20) begin
            error_cnt++;
            $display("BAD %0t bus gave no answer", $time);
            stop_test;
        end
    endtask
    task automatic cv(input logic [2:0] ch, input logic [15:0] d);
        @(posedge clk);
        conv <= {1'b1, ch, d};
        @(posedge clk);
        conv <= '0;
    endtask
    task automatic pr(input logic [7:0] a, input logic e);
        mam_host_model_inst.probe(a, ack);
        chk_bit(ack, e);
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        address = 8'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        byteenable = 4'h0;
        strap_lo = 1'b0;
        strap_hi = 1'b0;
        conv = '0;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, 8'(4 * i), 32'h0);
            chk_word(q, (i == 1) ? 32'h0000_00A0 : 32'h0);
        end
        bus(1'b1, 8'hFC, 32'hFF);
        bus(1'b0, 8'hFC, 32'h0);
        chk_word(q, 32'h0);
        pr(8'hA0, 1'b1);
        pr(8'hA8, 1'b0);
        $display("test factory state done");
        bus(1'b1, mam_pkg::REG_CFG_FIVE, 32'h08);
        for (int s = 0; s < 4; s++) begin
            sv = 2'(s);
            strap_lo <= sv[0];
            strap_hi <= sv[1];
            bus(1'b0, mam_pkg::REG_STATUS, 32'h0);
            chk_word(q, {22'h0, sv, 8'hA0 | {3'h0, sv, 3'h0}});
            pr(8'hA0 | {3'h0, sv, 3'h0}, 1'b1);
            pr(8'hA0 | {3'h0, ~sv, 3'h0}, 1'b0);
        end
        $display("test multipart done");
        bus(1'b1, mam_pkg::REG_CFG_TWO, 32'h60);
        bus(1'b1, mam_pkg::REG_CFG_FIVE, 32'h0);
        pr(8'h61, 1'b1);
        pr(8'hA0, 1'b0);
        bus(1'b0, mam_pkg::REG_STATUS, 32'h0);
        chk_word(q & 32'hFF, 32'h60);
        for (int i = 1; i >= 0; i--) begin
            bus(1'b1, mam_pkg::REG_CFG_ONE, 32'(i));
            bus(1'b1, mam_pkg::REG_CFG_THREE, 32'(i));
            @(posedge clk);
            chk_bit(mref, i[0]);
            chk_bit(ical, i[0]);
        end
        $display("test address and modes done");
        for (int i = 0; i < 5; i++) begin
            cv(3'(i), din[i]);
            bus(1'b0, mam_pkg::REG_TEMP + 8'(4 * i), 32'h0);
            chk_word(q, {16'h0, dex[i]});
        end
        bus(1'b0, mam_pkg::REG_CAL_BASE, 32'h0);
        chk_word(q, 32'h0100);
        bus(1'b1, mam_pkg::REG_CAL_BASE + 8'h0C, 32'hFFF6);
        bus(1'b0, mam_pkg::REG_CAL_BASE + 8'h0C, 32'h0);
        chk_word(q, 32'hFFF6);
        bus(1'b1, mam_pkg::REG_CAL_BASE, 32'h0180);
        bus(1'b1, mam_pkg::REG_CAL_BASE + 8'h04, 32'h0010);
        bus(1'b1, mam_pkg::REG_CFG_THREE, 32'h1);
        cv(mam_pkg::CH_VOLT, 16'h1001);
        bus(1'b0, mam_pkg::REG_VOLT, 32'h0);
        chk_word(q, 32'h1812);
        $display("test results done");
        stop_test;
    end
endmodule
`default_nettype wire
